// [gpt_pin_model.sv]
// Purpose: Model of the external count pin
// Assumes: Pin level changes just after a clock edge
// Notes: Pulses are two cycles high, two low
`timescale 1ns/100ps
module gpt_pin_model (
	input wire logic core_clk,
	output logic pin
);
	initial pin = 1'b0;
	// Edges for counting, levels for gating
	task automatic burst(input int n);
		repeat (n) begin
			@(posedge core_clk) pin <= 1'b1;
			repeat (2) @(posedge core_clk);
			pin <= 1'b0;
			@(posedge core_clk);
		end
	endtask : burst
endmodule : gpt_pin_model

// [gpt_pin_sync.sv]
// Purpose: Synchronise the external count pin and detect rising edges
// Assumes: Pin is asynchronous to core_clk
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module gpt_pin_sync
	import gpt_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic extCountInput,
	output gpt_pin_t pinInfo
);
	logic [2:0] syncReg;
	logic [2:0] syncNext;

	// Shift chain: two stages to settle, third for edge history
	always_comb begin
		syncNext = {syncReg[1:0], extCountInput};
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			syncReg <= 3'h0;
		end else begin
			syncReg <= syncNext;
		end
	end

	// Only stages 1 and 2 feed logic
	assign pinInfo.extRise = syncReg[1] & ~syncReg[2]; // [RULE_08]
	assign pinInfo.gateLevel = syncReg[1];
endmodule : gpt_pin_sync

// [gpt_pkg.sv]
// Purpose: Shared constants and types for the gated prescaled timer
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package gpt_pkg;
	// Register map
	localparam logic [11:0] GPT_CTRL_OFS = 12'h000;
	localparam logic [11:0] GPT_COUNT_OFS = 12'h004;
	localparam logic [11:0] GPT_STATUS_OFS = 12'h008;
	// Control field positions
	localparam int GPT_RUN_BIT = 15;
	localparam int GPT_IDLE_BIT = 13;
	localparam int GPT_GATE_BIT = 6;
	localparam int GPT_PS_LO = 4;
	localparam int GPT_CS_BIT = 1;
	// Writable bit mask and reset value of the control register
	localparam logic [15:0] GPT_CTRL_MASK = 16'hA072;
	localparam logic [15:0] GPT_CTRL_RESET = 16'h0000;
	localparam logic [15:0] GPT_COUNT_RESET = 16'h0000;
	// Prescaler terminal counts, minus one
	localparam logic [7:0] GPT_DIV1 = 8'h00;
	localparam logic [7:0] GPT_DIV8 = 8'h07;
	localparam logic [7:0] GPT_DIV64 = 8'h3F;
	localparam logic [7:0] GPT_DIV256 = 8'hFF;

	// Decoded control fields
	typedef struct packed {
		logic timerRun;
		logic haltWhenIdle;
		logic gateAccumulate;
		logic [1:0] prescaleSelect;
		logic clockSourceSelect;
	} gpt_ctrl_t;

	// Events from the input conditioner
	typedef struct packed {
		logic extRise;
		logic gateLevel;
	} gpt_pin_t;
endpackage : gpt_pkg

// [gpt_timer.sv]
// Purpose: 16-bit timer with prescaler, gating, source select and APB control
// Assumes: core_clk is the instruction-cycle clock; external pin doubles as gate
// Notes: Count register is readable and writable; status shows activity
//        Read data is loaded in the setup cycle, so a count read shows that moment
//        Address map: control at 0x000, count at 0x004, status at 0x008
//
// Functional notes
// [RULE_01] Run bit one starts the 16-bit timer, zero stops counting.
// [RULE_02] Idle-halt set: timer suspends all operation in idle mode.
// [RULE_03] Idle-halt clear: timer keeps running normally in idle mode.
// [RULE_04] Gate bit enables gated accumulation on internal clock; ignored on external.
// [RULE_05] Prescale field: 11 is 1:256, 10 1:64, 01 1:8, 00 1:1.
// [RULE_06] Source bit one counts external rising edges, zero uses instruction clock.
// [RULE_07] Control bits 14, 12-7, 3-2 read zero and ignore writes.
// [RULE_08] Count increments once per prescaler tick; external edges synchronised first.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
module gpt_timer
	import gpt_pkg::*;
#(
	parameter int CountWidth = 16
)(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic idleMode,
	input wire logic extCountInput,
	output logic [CountWidth-1:0] timerCount,
	output logic timerActive
);
	// Run states of the timer; one-hot so each state decodes from a single flop
	typedef enum logic [2:0] {
		GPT_RUN_STOPPED = 3'h1,
		GPT_RUN_COUNTING = 3'h2,
		GPT_RUN_SUSPENDED = 3'h4
	} gpt_run_state_t;

	// Control register and its next value
	logic [15:0] ctrlReg;
	logic [15:0] ctrlNext;
	// Count register and its next value
	logic [CountWidth-1:0] countReg;
	logic [CountWidth-1:0] countNext;
	// Prescaler accumulator; eight bits reach the largest ratio
	logic [7:0] preReg;
	logic [7:0] preNext;

	// Run state and the registered activity flag
	gpt_run_state_t runStateReg;
	gpt_run_state_t runStateNext;
	logic activeReg;
	logic activeNext;
	// Bus response, loaded in the setup cycle
	logic [31:0] rdataReg;
	logic [31:0] rdataNext;
	logic errReg;
	logic errNext;

	// Decoded control fields and conditioned pin events
	gpt_ctrl_t ctrl;
	gpt_pin_t pinInfo;
	// Bus phase and address decode
	logic setupPhase;
	logic accessPhase;
	logic selCtrl;
	logic selCount;
	logic selStatus;
	logic addrOk;
	logic wrCtrl;
	logic wrCount;

	// Count qualification
	logic suspended;
	logic runAllowed;
	logic srcTick;
	logic [7:0] divLimit;
	logic preTerminal;
	logic preTick;

	// Gate level and count edge share one pin, so both see the same synchroniser delay
	gpt_pin_sync uPinSync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.extCountInput(extCountInput),
		.pinInfo(pinInfo)
	);

	// Field decode of the control register
	always_comb begin
		ctrl.timerRun = ctrlReg[GPT_RUN_BIT];
		ctrl.haltWhenIdle = ctrlReg[GPT_IDLE_BIT];
		ctrl.gateAccumulate = ctrlReg[GPT_GATE_BIT];
		ctrl.prescaleSelect = ctrlReg[GPT_PS_LO+1:GPT_PS_LO];
		ctrl.clockSourceSelect = ctrlReg[GPT_CS_BIT];
	end

	// Bus phases; the slave never stretches a transfer, so ready is tied high
	// Limitation: a setup cycle is taken to last exactly one clock, as the bus requires
	assign setupPhase = psel & ~penable;
	assign accessPhase = psel & penable;
	assign pready = 1'h1;

	// One-hot address decode; anything else is answered with an error
	always_comb begin
		selCtrl = 1'h0;
		selCount = 1'h0;
		selStatus = 1'h0;
		case (paddr)
			GPT_CTRL_OFS: begin
				selCtrl = 1'h1;
			end
			GPT_COUNT_OFS: begin
				selCount = 1'h1;
			end
			GPT_STATUS_OFS: begin
				selStatus = 1'h1;
			end
			default: begin
				// Unmapped word: no select, the response carries an error
				selCtrl = 1'h0;
			end
		endcase
	end

	// Writes take effect only at the access edge, and only to mapped words
	assign addrOk = selCtrl | selCount | selStatus;
	assign wrCtrl = accessPhase & pwrite & selCtrl;
	assign wrCount = accessPhase & pwrite & selCount;

	// Idle suspension only when the halt bit asks for it
	assign suspended = idleMode & ctrl.haltWhenIdle; // [RULE_02] [RULE_03]
	assign runAllowed = ctrl.timerRun & ~suspended; // [RULE_01]

	// Source selection and gating
	always_comb begin
		if (ctrl.clockSourceSelect) begin
			srcTick = pinInfo.extRise; // [RULE_06] [RULE_04]
		end else if (ctrl.gateAccumulate) begin
			srcTick = pinInfo.gateLevel; // [RULE_04]
		end else begin
			srcTick = 1'b1; // [RULE_06]
		end
	end

	// Prescaler ratio
	always_comb begin
		case (ctrl.prescaleSelect) // [RULE_05]
			2'b00: divLimit = GPT_DIV1;
			2'b01: divLimit = GPT_DIV8;
			2'b10: divLimit = GPT_DIV64;
			2'b11: divLimit = GPT_DIV256;
			default: divLimit = GPT_DIV1;
		endcase
	end

	// Terminal test uses >= so a ratio lowered in mid-count does not run the full eight bits
	assign preTerminal = (preReg >= divLimit);
	// One count tick per prescaler wrap, and only while the timer may run
	assign preTick = runAllowed & srcTick & preTerminal; // [RULE_08]

	// Run state next value; the state follows the run bit and the idle halt
	// Stopped: run bit clear. Suspended: run bit set but held by the idle halt
	always_comb begin
		runStateNext = runStateReg;
		case (runStateReg)
			GPT_RUN_STOPPED: begin
				if (runAllowed) begin
					runStateNext = GPT_RUN_COUNTING; // [RULE_01]
				end else if (ctrl.timerRun) begin
					runStateNext = GPT_RUN_SUSPENDED; // [RULE_02]
				end
			end
			GPT_RUN_COUNTING: begin
				if (!ctrl.timerRun) begin
					runStateNext = GPT_RUN_STOPPED; // [RULE_01]
				end else if (suspended) begin
					runStateNext = GPT_RUN_SUSPENDED; // [RULE_02]
				end
			end
			GPT_RUN_SUSPENDED: begin
				if (!ctrl.timerRun) begin
					runStateNext = GPT_RUN_STOPPED;
				end else if (!suspended) begin
					runStateNext = GPT_RUN_COUNTING; // [RULE_03]
				end
			end
			default: begin
				runStateNext = GPT_RUN_STOPPED;
			end
		endcase
		// Activity is the counting state, shown one edge later as the status bit
		activeNext = (runStateNext == GPT_RUN_COUNTING);
	end

	// Run state and activity flag; the flag lags the control bit by one edge
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			runStateReg <= GPT_RUN_STOPPED;
			activeReg <= 1'h0;
		end else begin
			runStateReg <= runStateNext;
			activeReg <= activeNext;
		end
	end

	// Prescaler next value; cleared on stop, held while idle-suspended
	always_comb begin
		preNext = preReg;
		if (!ctrl.timerRun) begin
			preNext = 8'h00; // A restart begins a full prescale period
		end else if (runAllowed && srcTick) begin
			preNext = preTerminal ? 8'h00 : preReg + 8'h01; // [RULE_05]
		end
	end

	// Prescaler register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			preReg <= 8'h00;
		end else begin
			preReg <= preNext;
		end
	end

	// Count next value; a bus write to the count wins over an increment in the same cycle
	always_comb begin
		countNext = countReg;
		if (wrCount) begin
			countNext = pwdata[CountWidth-1:0];
		end else if (preTick) begin
			countNext = countReg + {{(CountWidth-1){1'h0}}, 1'h1}; // [RULE_08]
		end
	end

	// Count register; wraps from all ones to zero without any flag
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			countReg <= CountWidth'(GPT_COUNT_RESET);
		end else begin
			countReg <= countNext;
		end
	end

	// Control next value; only implemented bits are ever stored
	always_comb begin
		ctrlNext = ctrlReg;
		if (wrCtrl) begin
			ctrlNext = pwdata[15:0] & GPT_CTRL_MASK; // [RULE_07]
		end
	end

	// Control register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrlReg <= GPT_CTRL_RESET;
		end else begin
			ctrlReg <= ctrlNext;
		end
	end

	// Read data and error are loaded in the setup cycle and cleared after the access,
	// so they come straight from flops and read zero outside a transfer
	always_comb begin
		rdataNext = 32'h0000_0000;
		errNext = 1'h0;
		if (setupPhase) begin
			errNext = ~addrOk;
			if (!pwrite) begin
				if (selCtrl) begin
					rdataNext = {16'h0000, ctrlReg & GPT_CTRL_MASK}; // [RULE_07]
				end else if (selCount) begin
					rdataNext = {{(32-CountWidth){1'h0}}, countReg}; // [RULE_08]
				end else if (selStatus) begin
					rdataNext = {31'h0000_0000, activeReg}; // [RULE_01]
				end
			end
		end
	end

	// Response registers
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdataReg <= 32'h0000_0000;
			errReg <= 1'h0;
		end else begin
			rdataReg <= rdataNext;
			errReg <= errNext;
		end
	end

	// Outputs straight from flops
	// Limitation: period match and overflow events are left to the surrounding logic
	assign prdata = rdataReg;
	assign pslverr = errReg;
	assign timerCount = countReg;
	assign timerActive = activeReg;
endmodule : gpt_timer

// [gpt_timer_bench.sv]
// Purpose: Self-checking bench for the timer
// Assumes: Prescaler ticks at its terminal count
// Notes: Rows cover modes; reset and fields after
`timescale 1ns/100ps
module gpt_timer_bench
	import gpt_pkg::*;
;
	typedef struct {logic [15:0] c; logic i; int p; int k; logic [15:0] e;} gpt_row_t;
	logic core_clk, sys_rst, psel, penable, pwrite, idleMode, extCountInput, pready, pslverr, timerActive, ev;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [15:0] timerCount;
	int errors, tests_run;
	// Control, idle, pulses, wait, expected count
	gpt_row_t rows[10] = '{'{16'h8000, 0, 0, 7, 10}, '{16'h8010, 0, 0, 13, 2}, '{16'h8020, 0, 0, 125, 2},
		'{16'h8030, 0, 0, 509, 2}, '{16'hA000, 1, 0, 7, 0}, '{16'hA000, 0, 0, 7, 10}, '{16'h8000, 1, 0, 7, 10},
		'{16'h8040, 0, 5, 4, 10}, '{16'h8042, 0, 5, 4, 5}, '{16'h0002, 0, 5, 4, 0}};
	gpt_timer u_gpt_timer (.*);
	gpt_pin_model u_gpt_pin_model (.core_clk(core_clk), .pin(extCountInput));
	task automatic end_of_test();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// One APB transfer; a stuck access ends the run
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 9);
		if (pready !== 1'b1) begin
			errors++;
			end_of_test();
		end
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		{sys_rst, psel, penable, pwrite, idleMode, paddr, pwdata} = {1'b1, 4'h0, 12'h000, 32'h0};
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		foreach (rows[j]) begin
			idleMode <= rows[j].i;
			apb(1'b1, GPT_COUNT_OFS, 32'h0);
			apb(1'b1, GPT_CTRL_OFS, {16'h0, rows[j].c});
			u_gpt_pin_model.burst(rows[j].p);
			repeat (rows[j].k) @(posedge core_clk);
			apb(1'b1, GPT_CTRL_OFS, 32'h0);
			apb(1'b0, GPT_COUNT_OFS, 32'h0);
			chk("count", rv, {16'h0, rows[j].e});
		end
		// Unused bits only, then an unmapped word
		apb(1'b1, GPT_CTRL_OFS, 32'hFFFF5F8C);
		apb(1'b0, GPT_CTRL_OFS, 32'h0);
		chk("ctrl", rv, 32'h0);
		apb(1'b0, 12'h00C, 32'h0);
		chk("err", {31'h0, ev}, 32'h1);
		// Reset in mid-run clears count and activity
		apb(1'b1, GPT_CTRL_OFS, 32'h8000);
		apb(1'b0, GPT_STATUS_OFS, 32'h0);
		chk("active", rv, 32'h1);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("cnt rst", {15'h0, timerCount, timerActive}, 32'h0);
		sys_rst <= 1'b0;
		apb(1'b0, GPT_CTRL_OFS, 32'h0);
		chk("ctrl rst", rv, {16'h0, GPT_CTRL_RESET});
		end_of_test();
	end
endmodule : gpt_timer_bench

// [gpt_timer_properties.sv]
// Purpose: Port checks for the timer
// Assumes: Bound to every timer instance
// Notes: No view of internal state
`timescale 1ns/100ps
module gpt_timer_properties
	import gpt_pkg::*;
#(
	parameter int CountWidth = 16
)(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic timerActive,
	input wire logic [CountWidth-1:0] timerCount
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Access phase decodes
	wire rd = psel && penable && !pwrite;
	wire cw = psel && penable && pwrite && paddr == GPT_COUNT_OFS;
	// Three quiet cycles cover the registered active flag lag
	sequence quiet_s;
		(!timerActive && !cw)[*3];
	endsequence
	zero_wait_a: assert property (pready) else $error("pready low");
	bad_addr_a: assert property (psel && penable && paddr > GPT_STATUS_OFS |-> pslverr && prdata == 32'h0)
		else $error("unmapped access");
	ctrl_unused_a: assert property (rd && paddr == GPT_CTRL_OFS |-> prdata[31:16] == 16'h0 &&
		(prdata[15:0] & ~GPT_CTRL_MASK) == 16'h0) else $error("unused bit set");
	// Read data is loaded at the end of setup, so reads compare with the value one edge back
	status_read_a: assert property (rd && paddr == GPT_STATUS_OFS |-> prdata == {31'h0, $past(timerActive)})
		else $error("status wrong");
	count_read_a: assert property (rd && paddr == GPT_COUNT_OFS |-> prdata[15:0] == $past(timerCount))
		else $error("count read wrong");
	count_step_a: assert property (!$past(cw) && !$stable(timerCount) |->
		timerCount == $past(timerCount) + 1'b1) else $error("count jump");
	stopped_hold_a: assert property (quiet_s |-> $stable(timerCount)) else $error("count moved");
	count_write_a: assert property (cw |=> timerCount == $past(pwdata[15:0])) else $error("count write lost");
endmodule : gpt_timer_properties
bind gpt_timer gpt_timer_properties #(.CountWidth(CountWidth)) u_gpt_timer_properties (.*);
